// ---- rtl/utc_core.v ----
// serial transmit and receive core with transmit versus line check
//
// Summary of operation
// - master mode: compare sent char with line readback; mismatch sets flag, status irq
// - no comparison while only receiving
// - comparison runs with receiver off; then rx irqs and rx flags are suppressed
// - tx buffer write starts sending: move to shift reg, send framed bits
// - tx ready irq when buffered char enters the shift register
// - a buffer write before the move replaces the waiting char
// - clearing power or transmit enable while active aborts sending
// - two base clocks idle between stop bit and next start bit
// - falling edge, then half bit later still low accepts a start bit
// - bits shift in at baud rate; stop bit copies char and flags done
// - overrun discards the new char, old data stays
// - parity or framing error still copies the char at first stop bit
// - any reception error gives status irq instead of done irq
// - only the first stop bit is checked
// - next start bit detectable right after a stop bit
// - a line held low is never a start bit; an edge is needed
// - parity mismatch, missing stop bit and unread data raise their flags
// - error flags hold until software writes zero to them
// - done irq only while power and receive enable are still set
// - frame: start, 7 or 8 bits either order, optional parity, 1 or 2 stops
// - input filter needs three equal samples; three clocks of latency
// - even and odd parity count ones; zero parity sends 0, unchecked
`timescale 1ns/10ps
`include "utc_consts.vh"

module utc_core (
    input wire clk,
    input wire reset_n,
    input wire [2:0] addr,
    input wire [7:0] wrData,
    input wire wrStb,
    input wire rdStb,
    output reg [7:0] rdData_q,
    input wire serialIn,
    output reg serialOut_q,
    output reg txReadyIrq_q,
    output reg rxDoneIrq_q,
    output reg statusIrq_q
);
    localparam [2:0] TX_IDLE = 3'b001;
    localparam [2:0] TX_SEND = 3'b010;
    localparam [2:0] TX_GAP = 3'b100;
    localparam [2:0] RX_IDLE = 3'b001;
    localparam [2:0] RX_START = 3'b010;
    localparam [2:0] RX_BITS = 3'b100;

    // character length from frame format
    function [3:0] charLen;
        input [7:0] c;
        begin
            charLen = c[`UTC_F_LEN8] ? 4'h8 : 4'h7;
        end
    endfunction

    // parity bit for a character; zero parity gives 0
    function parBit;
        input [7:0] d;
        input [7:0] c;
        reg [7:0] m;
        begin
            m = c[`UTC_F_LEN8] ? d : {1'b0, d[6:0]};
            parBit = (c[`UTC_F_PAR_HI:`UTC_F_PAR_LO] == `UTC_PAR_EVEN) ? (^m) :
                (c[`UTC_F_PAR_HI:`UTC_F_PAR_LO] == `UTC_PAR_ODD) ? ~(^m) : 1'b0;
        end
    endfunction

    // full frame, bit 0 sent first, unused tail is stop level
    function [11:0] txFrame;
        input [7:0] d;
        input [7:0] c;
        integer i;
        integer n;
        begin
            txFrame = 12'hfff;
            n = charLen(c);
            txFrame[0] = 1'b0;
            for (i = 0; i < 8; i = i + 1) begin
                if (i < n) begin
                    txFrame[1 + i] = c[`UTC_F_MSB] ? d[n - 1 - i] : d[i];
                end
            end
            if (c[`UTC_F_PAR_HI:`UTC_F_PAR_LO] != `UTC_PAR_NONE) begin
                txFrame[1 + n] = parBit(d, c);
            end
        end
    endfunction

    // number of bits on the line for one frame
    function [3:0] txLen;
        input [7:0] c;
        begin
            txLen = 4'h1 + charLen(c) + {3'h0, c[`UTC_F_PAR_HI:`UTC_F_PAR_LO] != `UTC_PAR_NONE}
                + (c[`UTC_F_STOP2] ? 4'h2 : 4'h1);
        end
    endfunction

    // reset release through two flops
    reg [1:0] rstSync_q;
    wire rstN = rstSync_q[1];
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end

    reg [7:0] frame_q;
    reg [7:0] baud_q;
    reg [7:0] opt_q;
    reg [7:0] txBuf_q;
    reg txBufFull_q;
    reg [7:0] rxData_q;
    reg rxUnread_q;
    reg dce_q;
    reg pe_q;
    reg fe_q;
    reg ove_q;
    reg [2:0] txState_q;
    reg [11:0] txShift_q;
    reg [3:0] txBits_q;
    reg [7:0] txTimer_q;
    reg [1:0] txGap_q;
    reg [7:0] txCmp_q;
    reg cmpPend_q;
    reg [1:0] rxSmp_q;
    reg rxFilt_q;
    reg rxPrev_q;
    reg [2:0] rxState_q;
    reg [7:0] rxTimer_q;
    reg [3:0] rxIdx_q;
    reg [7:0] rxShift_q;
    reg rxPar_q;

    wire power = frame_q[`UTC_F_PWR];
    wire txOn = power & frame_q[`UTC_F_TXE];
    wire rxEn = power & frame_q[`UTC_F_RXE];
    wire master = opt_q[`UTC_O_MASTER];
    wire [7:0] bitLen = (baud_q < `UTC_BAUD_MIN) ? `UTC_BAUD_MIN : baud_q;
    wire [3:0] nChar = charLen(frame_q);
    wire parOn = frame_q[`UTC_F_PAR_HI:`UTC_F_PAR_LO] != `UTC_PAR_NONE;
    wire parChk = frame_q[`UTC_F_PAR_HI];
    wire wrFrame = wrStb && (addr == `UTC_ADDR_FRAME);
    wire wrTxBuf = wrStb && (addr == `UTC_ADDR_TXBUF);
    wire wrStatus = wrStb && (addr == `UTC_ADDR_STATUS);
    wire rdRxData = rdStb && (addr == `UTC_ADDR_RXDATA);
    wire txActive = (txState_q != TX_IDLE) | txBufFull_q;

    // transmit: load, send bits, gap
    wire txBitEnd = (txState_q == TX_SEND) && (txTimer_q == 8'h00);
    wire txLastBit = txBitEnd && (txBits_q == 4'h1);
    wire txLoad = txOn && txBufFull_q &&
        ((txState_q == TX_IDLE) || ((txState_q == TX_GAP) && (txGap_q == 2'h1)));

    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            txState_q <= TX_IDLE;
            txShift_q <= 12'hfff;
            txBits_q <= 4'h0;
            txTimer_q <= 8'h00;
            txGap_q <= 2'h0;
            txBufFull_q <= 1'b0;
        end else if (!txOn) begin
            txState_q <= TX_IDLE;
            txShift_q <= 12'hfff;
            txBufFull_q <= 1'b0;
        end else begin
            if (wrTxBuf) begin
                txBufFull_q <= 1'b1;
            end else if (txLoad) begin
                txBufFull_q <= 1'b0;
            end
            case (txState_q)
                TX_IDLE: begin
                    if (txLoad) begin
                        txState_q <= TX_SEND;
                        txShift_q <= txFrame(txBuf_q, frame_q);
                        txBits_q <= txLen(frame_q);
                        txTimer_q <= bitLen - 8'h01;
                    end
                end
                TX_SEND: begin
                    if (txLastBit) begin
                        txState_q <= TX_GAP;
                        txGap_q <= `UTC_TX_GAP;
                        txShift_q <= 12'hfff;
                    end else if (txBitEnd) begin
                        txShift_q <= {1'b1, txShift_q[11:1]};
                        txBits_q <= txBits_q - 4'h1;
                        txTimer_q <= bitLen - 8'h01;
                    end else begin
                        txTimer_q <= txTimer_q - 8'h01;
                    end
                end
                TX_GAP: begin
                    if (txLoad) begin
                        txState_q <= TX_SEND;
                        txShift_q <= txFrame(txBuf_q, frame_q);
                        txBits_q <= txLen(frame_q);
                        txTimer_q <= bitLen - 8'h01;
                    end else if (txGap_q == 2'h1) begin
                        txState_q <= TX_IDLE;
                    end else begin
                        txGap_q <= txGap_q - 2'h1;
                    end
                end
                default: begin
                    txState_q <= TX_IDLE;
                end
            endcase
        end
    end

    // input filter: two stored samples must match the pin, so 2-clock runts never pass
    wire rxIn = serialIn ^ opt_q[`UTC_O_RXINV];
    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            rxSmp_q <= 2'h3;
            rxFilt_q <= 1'b1;
            rxPrev_q <= 1'b1;
        end else begin
            rxSmp_q <= {rxSmp_q[0], rxIn};
            if ((rxSmp_q[1] == rxSmp_q[0]) && (rxSmp_q[0] == rxIn)) begin
                rxFilt_q <= rxSmp_q[1];
            end
            rxPrev_q <= rxFilt_q;
        end
    end

    // receiver runs when enabled or when a sent char awaits readback
    wire rxRun = power & (frame_q[`UTC_F_RXE] | (master & cmpPend_q));
    wire [3:0] rxNeed = nChar + {3'h0, parOn} + 4'h1;
    wire rxTick = (rxState_q == RX_BITS) && (rxTimer_q == 8'h00);
    wire rxStop = rxTick && (rxIdx_q == rxNeed - 4'h1);
    wire rxBit = rxFilt_q;
    wire [7:0] rxChar = frame_q[`UTC_F_MSB] ?
        (frame_q[`UTC_F_LEN8] ? rxShift_q : {1'b0, rxShift_q[6:0]}) :
        (frame_q[`UTC_F_LEN8] ? rxShift_q : {1'b0, rxShift_q[7:1]});

    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            rxState_q <= RX_IDLE;
            rxTimer_q <= 8'h00;
            rxIdx_q <= 4'h0;
            rxShift_q <= 8'h00;
            rxPar_q <= 1'b0;
        end else if (!rxRun) begin
            rxState_q <= RX_IDLE;
        end else begin
            case (rxState_q)
                RX_IDLE: begin
                    if (rxPrev_q && !rxFilt_q) begin
                        rxState_q <= RX_START;
                        rxTimer_q <= {1'b0, bitLen[7:1]} - 8'h01;
                    end
                end
                RX_START: begin
                    if (rxTimer_q != 8'h00) begin
                        rxTimer_q <= rxTimer_q - 8'h01;
                    end else if (!rxFilt_q) begin
                        rxState_q <= RX_BITS;
                        rxTimer_q <= bitLen - 8'h01;
                        rxIdx_q <= 4'h0;
                    end else begin
                        rxState_q <= RX_IDLE;
                    end
                end
                RX_BITS: begin
                    if (rxTimer_q != 8'h00) begin
                        rxTimer_q <= rxTimer_q - 8'h01;
                    end else if (rxStop) begin
                        rxState_q <= RX_IDLE;
                    end else begin
                        rxTimer_q <= bitLen - 8'h01;
                        rxIdx_q <= rxIdx_q + 4'h1;
                        if (rxIdx_q < nChar) begin
                            rxShift_q <= frame_q[`UTC_F_MSB] ? {rxShift_q[6:0], rxBit} :
                                {rxBit, rxShift_q[7:1]};
                        end else begin
                            rxPar_q <= rxBit;
                        end
                    end
                end
                default: begin
                    rxState_q <= RX_IDLE;
                end
            endcase
        end
    end

    // end of character: errors, transfer and readback compare
    wire rxNormal = rxStop && rxEn;
    wire errPar = rxNormal && parOn && parChk && (rxPar_q != parBit(rxChar, frame_q));
    wire errFrm = rxNormal && !rxBit;
    wire errOvr = rxNormal && rxUnread_q;
    wire rxErr = errPar | errFrm | errOvr;
    wire cmpNow = rxStop && master && cmpPend_q;
    wire cmpBad = cmpNow && (rxChar != (frame_q[`UTC_F_LEN8] ? txCmp_q : {1'b0, txCmp_q[6:0]}));

    // register file, sticky flags with set winning over clear
    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            frame_q <= `UTC_FRAME_RST;
            baud_q <= `UTC_BAUD_RST;
            opt_q <= `UTC_OPT_RST;
            txBuf_q <= `UTC_TXBUF_RST;
            rxData_q <= `UTC_RXDATA_RST;
            rxUnread_q <= 1'b0;
            txCmp_q <= 8'h00;
            cmpPend_q <= 1'b0;
            dce_q <= 1'b0;
            pe_q <= 1'b0;
            fe_q <= 1'b0;
            ove_q <= 1'b0;
        end else begin
            if (wrFrame) begin
                frame_q <= wrData;
            end
            if (wrStb && (addr == `UTC_ADDR_BAUD)) begin
                baud_q <= wrData;
            end
            if (wrStb && (addr == `UTC_ADDR_OPT)) begin
                opt_q <= wrData;
            end
            if (wrTxBuf) begin
                txBuf_q <= wrData;
            end
            if (txLoad && master) begin
                txCmp_q <= txBuf_q;
                cmpPend_q <= 1'b1;
            end else if (cmpNow || !txOn) begin
                cmpPend_q <= 1'b0;
            end
            if (rxNormal && !errOvr) begin
                rxData_q <= rxChar;
            end
            if (rxNormal && !errOvr) begin
                rxUnread_q <= 1'b1;
            end else if (rdRxData || !rxEn) begin
                rxUnread_q <= 1'b0;
            end
            dce_q <= cmpBad | (dce_q & ~(wrStatus & ~wrData[`UTC_S_DCE]));
            pe_q <= errPar | (pe_q & ~(wrStatus & ~wrData[`UTC_S_PE]));
            fe_q <= errFrm | (fe_q & ~(wrStatus & ~wrData[`UTC_S_FE]));
            ove_q <= errOvr | (ove_q & ~(wrStatus & ~wrData[`UTC_S_OVE]));
        end
    end

    // interrupt pulses and serial output
    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            txReadyIrq_q <= 1'b0;
            rxDoneIrq_q <= 1'b0;
            statusIrq_q <= 1'b0;
            serialOut_q <= 1'b1;
        end else begin
            txReadyIrq_q <= txLoad;
            rxDoneIrq_q <= rxNormal && !rxErr;
            statusIrq_q <= rxErr | cmpBad;
            serialOut_q <= txShift_q[0] ^ opt_q[`UTC_O_TXINV];
        end
    end

    // read data one cycle after the strobe
    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            rdData_q <= 8'h00;
        end else if (rdStb) begin
            case (addr)
                `UTC_ADDR_FRAME: rdData_q <= frame_q;
                `UTC_ADDR_BAUD: rdData_q <= baud_q;
                `UTC_ADDR_OPT: rdData_q <= opt_q;
                `UTC_ADDR_TXBUF: rdData_q <= txBuf_q;
                `UTC_ADDR_RXDATA: rdData_q <= rxData_q;
                `UTC_ADDR_STATUS: rdData_q <= {txActive, 3'h0, dce_q, pe_q, fe_q, ove_q};
                default: rdData_q <= 8'h00;
            endcase
        end else begin
            rdData_q <= 8'h00;
        end
    end
endmodule // utc_core

// ---- rtl/utc_consts.vh ----
// constants for the serial transmit and receive core
`ifndef UTC_CONSTS_VH
`define UTC_CONSTS_VH
// register offsets
`define UTC_ADDR_FRAME 3'h0
`define UTC_ADDR_BAUD 3'h1
`define UTC_ADDR_OPT 3'h2
`define UTC_ADDR_TXBUF 3'h3
`define UTC_ADDR_RXDATA 3'h4
`define UTC_ADDR_STATUS 3'h5
// frame format fields
`define UTC_F_PWR 7
`define UTC_F_TXE 6
`define UTC_F_RXE 5
`define UTC_F_MSB 4
`define UTC_F_PAR_HI 3
`define UTC_F_PAR_LO 2
`define UTC_F_LEN8 1
`define UTC_F_STOP2 0
// parity codes
`define UTC_PAR_NONE 2'h0
`define UTC_PAR_ZERO 2'h1
`define UTC_PAR_ODD 2'h2
`define UTC_PAR_EVEN 2'h3
// line option fields
`define UTC_O_RXINV 0
`define UTC_O_TXINV 1
`define UTC_O_MASTER 2
// status fields
`define UTC_S_TXACT 7
`define UTC_S_DCE 3
`define UTC_S_PE 2
`define UTC_S_FE 1
`define UTC_S_OVE 0
// reset values
`define UTC_FRAME_RST 8'h0a
`define UTC_BAUD_RST 8'h10
`define UTC_OPT_RST 8'h00
`define UTC_RXDATA_RST 8'hff
`define UTC_TXBUF_RST 8'hff
// timing in base clocks
`define UTC_TX_GAP 2'h2
`define UTC_BAUD_MIN 8'h02
`endif

// ---- sim/utc_core_assertions.sv ----
// port checker for the serial core
`timescale 1ns/10ps
module utc_core_checker (
    input wire clk,
    input wire reset_n,
    input wire [2:0] addr,
    input wire [7:0] wrData,
    input wire wrStb,
    input wire rdStb,
    input wire [7:0] rdData_q,
    input wire serialIn,
    input wire serialOut_q,
    input wire txReadyIrq_q,
    input wire rxDoneIrq_q,
    input wire statusIrq_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // interrupt pulses, frame timing and unmapped reads
    a_irq_not_both: assert property (!(rxDoneIrq_q && statusIrq_q))
        else $error("done and status irq together");
    a_tx_irq_pulse: assert property (txReadyIrq_q |=> !txReadyIrq_q)
        else $error("tx irq longer than one cycle");
    a_frame_min_len: assert property (txReadyIrq_q |=> !txReadyIrq_q [*8])
        else $error("reload inside a frame");
    a_start_after_load: assert property (txReadyIrq_q |=> !serialOut_q ##1 !serialOut_q)
        else $error("no start bit after load");
    a_gap_before_start: assert property (txReadyIrq_q |-> $past(serialOut_q)
        && $past(serialOut_q, 2) && $past(serialOut_q, 3) && $past(serialOut_q, 4))
        else $error("idle gap too short");
    a_rx_done_pulse: assert property (rxDoneIrq_q |=> !rxDoneIrq_q)
        else $error("done irq longer than one cycle");
    a_status_pulse: assert property (statusIrq_q |=> !statusIrq_q)
        else $error("status irq longer than one cycle");
    a_unmapped_read: assert property (rdStb && addr[2:1] == 2'h3 |=> rdData_q == 8'h00)
        else $error("unmapped read not zero");
    // main scenarios
    c_tx: cover property (txReadyIrq_q);
    c_rx: cover property (rxDoneIrq_q);
    c_status: cover property (statusIrq_q);
endmodule // utc_core_checker
bind utc_core utc_core_checker u_chk (.clk(clk), .reset_n(reset_n), .addr(addr),
    .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData_q(rdData_q),
    .serialIn(serialIn), .serialOut_q(serialOut_q), .txReadyIrq_q(txReadyIrq_q),
    .rxDoneIrq_q(rxDoneIrq_q), .statusIrq_q(statusIrq_q));

// ---- sim/utc_remote_node.sv ----
// remote serial node model for the serial core bench
`timescale 1ns/10ps
module utc_remote_node #(
    parameter integer BIT = 4
) (
    input wire clk,
    input wire txLine,
    output wire rxLine
);
    logic drv = 1'b1;
    logic loopOn = 1'b0;
    logic cut = 1'b0;
    integer run = 0;
    integer lastRun = 0;
    // idle mark level; loopback echoes the line, optionally pulled low
    assign rxLine = loopOn ? (txLine & ~cut) : drv;
    // length of the high stretch before each falling edge
    always @(posedge clk) begin
        if (txLine) begin
            run <= run + 1;
        end else begin
            if (run != 0) begin
                lastRun <= run;
            end
            run <= 0;
        end
    end
    // n bits lsb first, each BIT clocks; patterns end high
    task sendBits(input [11:0] pat, input integer n);
        integer i;
        begin
            for (i = 0; i < n; i = i + 1) begin
                @(posedge clk);
                drv <= pat[i];
                repeat (BIT - 1) @(posedge clk);
            end
        end
    endtask
    // short low glitch
    task runt(input integer n);
        begin
            @(posedge clk);
            drv <= 1'b0;
            repeat (n) @(posedge clk);
            drv <= 1'b1;
        end
    endtask
    // decode one 8-bit lsb-first frame, returns mid stop bit
    task grabByte(output [7:0] b);
        integer i;
        begin
            @(posedge clk);
            while (txLine) @(posedge clk);
            repeat (BIT / 2) @(posedge clk);
            for (i = 0; i < 8; i = i + 1) begin
                repeat (BIT) @(posedge clk);
                b[i] = txLine;
            end
            repeat (BIT) @(posedge clk);
        end
    endtask
    // corrupt the echo during early data bits
    task cutBit;
        begin
            @(posedge clk);
            while (txLine) @(posedge clk);
            repeat (2 * BIT) @(posedge clk);
            cut <= 1'b1;
            repeat (BIT) @(posedge clk);
            cut <= 1'b0;
        end
    endtask
endmodule // utc_remote_node

// ---- sim/testbench.sv ----
// self-checking bench for the serial core
`timescale 1ns/10ps
`include "utc_consts.vh"
module testbench;
    logic clk = 1'b0;
    logic reset_n;
    logic [2:0] addr;
    logic [7:0] wrData;
    logic wrStb;
    logic rdStb;
    wire [7:0] rdData_q;
    wire serialIn;
    wire serialOut_q;
    wire txReadyIrq_q;
    wire rxDoneIrq_q;
    wire statusIrq_q;
    integer mismatches = 0;
    integer comparisons = 0;
    integer cnt [0:3] = '{0, 0, 0, 0};
    logic [7:0] rv;
    logic [7:0] b1;
    logic [7:0] b2;
    utc_core DUT (.clk(clk), .reset_n(reset_n), .addr(addr), .wrData(wrData),
        .wrStb(wrStb), .rdStb(rdStb), .rdData_q(rdData_q), .serialIn(serialIn),
        .serialOut_q(serialOut_q), .txReadyIrq_q(txReadyIrq_q),
        .rxDoneIrq_q(rxDoneIrq_q), .statusIrq_q(statusIrq_q));
    utc_remote_node #(.BIT(4)) u_node (.clk(clk), .txLine(serialOut_q), .rxLine(serialIn));
    initial begin
        forever #12.5 clk = ~clk;
    end
    // pulse counters: tx, done, status, done or status
    always @(posedge clk) begin
        if (txReadyIrq_q === 1'b1) cnt[0] <= cnt[0] + 1;
        if (rxDoneIrq_q === 1'b1) cnt[1] <= cnt[1] + 1;
        if (statusIrq_q === 1'b1) cnt[2] <= cnt[2] + 1;
        if (rxDoneIrq_q === 1'b1 || statusIrq_q === 1'b1) cnt[3] <= cnt[3] + 1;
    end
    task chk8(input [7:0] got, input [7:0] exp, input string what);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
            end
        end
    endtask
    task chkCnt(input integer got, input integer exp, input string what);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("wrong value at %0t: %s got %0d want %0d", $time, what, got, exp);
            end
        end
    endtask
    task wr(input [2:0] a, input [7:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wrData <= d;
            wrStb <= 1'b1;
            @(posedge clk);
            wrStb <= 1'b0;
        end
    endtask
    task rd(input [2:0] a, output [7:0] d);
        begin
            @(posedge clk);
            addr <= a;
            rdStb <= 1'b1;
            @(posedge clk);
            rdStb <= 1'b0;
            @(negedge clk);
            d = rdData_q;
        end
    endtask
    task waitIrq(input integer sel);
        integer c;
        integer i;
        begin
            c = cnt[sel];
            i = 0;
            while (cnt[sel] == c && i < 800) begin
                @(posedge clk);
                i = i + 1;
            end
            chkCnt(cnt[sel] - c, 1, "irq seen");
        end
    endtask
    task t_reset;
        logic [63:0] tbl;
        integer i;
        begin
            tbl = {24'h0, `UTC_RXDATA_RST, `UTC_TXBUF_RST, `UTC_OPT_RST, `UTC_BAUD_RST,
                `UTC_FRAME_RST};
            for (i = 0; i < 8; i = i + 1) begin
                rd(i[2:0], rv);
                chk8(rv, tbl[8 * i +: 8], "reset value");
            end
        end
    endtask
    task t_tx;
        integer c;
        begin
            c = cnt[0];
            wr(`UTC_ADDR_BAUD, 8'h04);
            wr(`UTC_ADDR_FRAME, 8'hc2);
            fork
                begin
                    u_node.grabByte(b1);
                    u_node.grabByte(b2);
                end
                begin
                    wr(`UTC_ADDR_TXBUF, 8'h00);
                    waitIrq(0);
                    wr(`UTC_ADDR_TXBUF, 8'h33);
                    wr(`UTC_ADDR_TXBUF, 8'h00);
                end
            join
            chk8(b1, 8'h00, "first byte");
            chk8(b2, 8'h00, "replaced byte");
            chkCnt(u_node.lastRun, 6, "idle gap");
            chkCnt(cnt[0] - c, 2, "tx irqs");
        end
    endtask
    task t_abort;
        begin
            wr(`UTC_ADDR_TXBUF, 8'hf0);
            repeat (12) @(posedge clk);
            rd(`UTC_ADDR_STATUS, rv);
            chk8(rv & 8'h80, 8'h80, "tx active");
            wr(`UTC_ADDR_FRAME, 8'h80);
            repeat (3) @(negedge clk);
            chk8({7'h0, serialOut_q}, 8'h01, "line idle");
            rd(`UTC_ADDR_STATUS, rv);
            chk8(rv & 8'h80, 8'h00, "tx stopped");
        end
    endtask
    task t_rx;
        integer c;
        begin
            wr(`UTC_ADDR_FRAME, 8'h00);
            wr(`UTC_ADDR_FRAME, 8'ha2);
            c = cnt[3];
            u_node.runt(2);
            repeat (60) @(posedge clk);
            chkCnt(cnt[3] - c, 0, "runt ignored");
            wr(`UTC_ADDR_FRAME, 8'h00);
            wr(`UTC_ADDR_OPT, 8'h01);
            repeat (4) @(posedge clk);
            wr(`UTC_ADDR_FRAME, 8'ha2);
            repeat (60) @(posedge clk);
            chkCnt(cnt[3] - c, 0, "low line ignored");
            wr(`UTC_ADDR_OPT, 8'h00);
            repeat (4) @(posedge clk);
            c = cnt[1];
            fork
                begin
                    u_node.sendBits({3'h7, 8'ha5, 1'b0}, 10);
                    u_node.sendBits({3'h7, 8'h3c, 1'b0}, 10);
                end
                begin
                    waitIrq(1);
                    rd(`UTC_ADDR_RXDATA, rv);
                    chk8(rv, 8'ha5, "rx data");
                    waitIrq(1);
                end
            join
            fork
                u_node.sendBits({3'h7, 8'h66, 1'b0}, 12);
                waitIrq(2);
            join
            chkCnt(cnt[1] - c, 2, "done irqs");
            rd(`UTC_ADDR_STATUS, rv);
            chk8(rv, 8'h01, "overrun only");
            rd(`UTC_ADDR_RXDATA, rv);
            chk8(rv, 8'h3c, "old data kept");
            wr(`UTC_ADDR_STATUS, 8'h00);
            rd(`UTC_ADDR_STATUS, rv);
            chk8(rv, 8'h00, "flags cleared");
        end
    endtask
    task t_err;
        integer i;
        integer c;
        logic [7:0] f;
        logic p;
        logic s;
        logic [7:0] e;
        begin
            for (i = 0; i < 6; i = i + 1) begin
                case (i)
                    0: {f, p, s, e} = {8'hae, 1'b1, 1'b1, 8'h04};
                    1: {f, p, s, e} = {8'hae, 1'b0, 1'b0, 8'h02};
                    2: {f, p, s, e} = {8'haa, 1'b1, 1'b1, 8'h00};
                    3: {f, p, s, e} = {8'haa, 1'b0, 1'b1, 8'h04};
                    4: {f, p, s, e} = {8'hbe, 1'b0, 1'b1, 8'h00};
                    default: {f, p, s, e} = {8'ha6, 1'b1, 1'b1, 8'h00};
                endcase
                wr(`UTC_ADDR_FRAME, 8'h00);
                wr(`UTC_ADDR_FRAME, f);
                c = cnt[1];
                fork
                    u_node.sendBits({1'b1, s, p, 8'h5a, 1'b0}, 12);
                    waitIrq(3);
                join
                rd(`UTC_ADDR_STATUS, rv);
                chk8(rv, e, "error flags");
                chkCnt(cnt[1] - c, (e == 8'h00) ? 1 : 0, "done irq");
                rd(`UTC_ADDR_RXDATA, rv);
                chk8(rv, 8'h5a, "data stored");
                wr(`UTC_ADDR_STATUS, 8'h00);
            end
        end
    endtask
    task t_dce;
        integer c;
        begin
            wr(`UTC_ADDR_FRAME, 8'h00);
            wr(`UTC_ADDR_OPT, 8'h04);
            wr(`UTC_ADDR_FRAME, 8'hc2);
            u_node.loopOn = 1'b1;
            c = cnt[1];
            fork
                u_node.cutBit;
                wr(`UTC_ADDR_TXBUF, 8'hff);
            join
            waitIrq(2);
            chkCnt(cnt[1] - c, 0, "no done irq");
            rd(`UTC_ADDR_STATUS, rv);
            chk8(rv & 8'h7f, 8'h08, "mismatch flag");
            wr(`UTC_ADDR_STATUS, 8'h00);
            c = cnt[2];
            wr(`UTC_ADDR_TXBUF, 8'h96);
            repeat (60) @(posedge clk);
            chkCnt(cnt[2] - c, 0, "clean echo");
            rd(`UTC_ADDR_STATUS, rv);
            chk8(rv & 8'h7f, 8'h00, "no flag");
        end
    endtask
    task final_report;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, mismatches);
            if (mismatches == 0 && comparisons > 0) begin
                $display("NO MISMATCHES");
            end else begin
                $display("MISMATCHES SEEN");
            end
            $finish;
        end
    endtask
    // main sequence
    initial begin
        reset_n = 1'b0;
        addr = 3'h0;
        wrData = 8'h00;
        wrStb = 1'b0;
        rdStb = 1'b0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset;
        $display("test reset values done");
        t_tx;
        $display("test transmit done");
        t_abort;
        $display("test abort done");
        t_rx;
        $display("test receive done");
        t_err;
        $display("test receive errors done");
        t_dce;
        $display("test readback check done");
        final_report;
    end
    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        mismatches = mismatches + 1;
        final_report;
    end
endmodule // testbench
